// *** core/fpl_core.sv ***
// Flash protection checks and the software loader reset trigger.
// Assumes the protection word and run environment are stable
// between resets, and that flash busy comes from the flash controller.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Loader entry needs internal/external run, defined boot end, loader present.
// - E1h then 3Eh within 127 cycles requests loader entry reset.
// - After loader entry, non power-on resets keep entering loader mode.
// - E1h then 0Eh within 127 cycles resets out of loader mode.
// - Loader exit cancels earlier entry; blank flags count again.
// - Loader reset waits for flash busy to end, like watchdog.
// - Boot region starts at zero, ends programmable, at most 0077FFh.
// - CPU writes to boot region always refused; reads allowed.
// - Code and data writes need section enable and lock off.
// - One enable bit per 8K program or 512-byte data section.
// - Every reset clears all section write enables.
// - Sixteen sections per block, bit zero lowest address.
// - Two or more zero write lock bits enable global write lock.
// - Majority zero read lock bits block debug reads, not CPU.
// - Information blocks are outside CPU space, reached indirectly.
// - Main blocks decode at 000000-01FFFF, 020000-03FFFF, 0D0000-0D1FFF.
// - Program info blocks 000-07F and 080-0FF; data info 000-07F.
// - First info block readable, never writable; function word 07Eh.
// - Loader flag set by entry, cleared by exit or cold reset.
module fpl_core
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset cause and device environment
   input wire logic cold_reset,
   input wire logic internal_run_environment,
   input wire logic external_run_environment,
   input wire fpl_pkg::fpl_prot_word_s prot_word,
   input wire logic flash_busy,
   // Memory access checks
   input wire fpl_pkg::fpl_cpu_req_s cpu_req,
   output logic cpu_allow,
   input wire fpl_pkg::fpl_info_req_s info_req,
   output logic info_allow,
   input wire logic debug_read,
   output logic debug_read_allow,
   // Reset request and loader mode
   output logic loader_reset_req,
   output logic in_system_programming_mode
);

   // ==========================================================
   // State
   typedef enum logic [1:0] {st_idle, st_armed, st_wait} fpl_trig_e;

   typedef struct packed {
      fpl_trig_e trig;
      logic [6:0] cnt;
      logic entry_pending;
      logic [15:0] prog_low_wen;
      logic [15:0] prog_high_wen;
      logic [15:0] data_wen;
      logic sticky_entry;
      logic loader_flag;
      logic [31:0] rdata;
      logic reset_req;
   } fpl_state_s;

   fpl_state_s s_q;
   fpl_state_s s_d;

   // ==========================================================
   // Functions
   function automatic logic majority_zero(input logic [2:0] b);
      majority_zero = (b[0] ~^ b[1]) ? ~b[0] : ~b[2];
   endfunction : majority_zero

   function automatic logic in_range(input logic [23:0] a,
                                     input logic [23:0] lo,
                                     input logic [23:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // ==========================================================
   // Protection decode
   logic write_lock;
   logic read_lock;
   logic boot_defined;
   logic [23:0] boot_end;
   logic in_boot;
   logic in_main0;
   logic in_main1;
   logic in_data;
   logic sect_en;
   logic entry_ok;

   assign write_lock = majority_zero(prot_word.global_write_lock);
   assign read_lock = majority_zero(prot_word.global_read_lock);
   assign debug_read_allow = debug_read & ~read_lock;

   assign boot_defined = prot_word.boot_region_end != fpl_pkg::fpl_boot_undefined;
   assign boot_end = boot_defined ?
      {9'h000, prot_word.boot_region_end[2:0], 12'h000} + 24'h0007ff : 24'h0;
   assign in_boot = boot_defined && (cpu_req.addr <= boot_end) &&
                    (boot_end <= fpl_pkg::fpl_boot_max);

   assign in_main0 = in_range(cpu_req.addr, fpl_pkg::fpl_main0_lo,
                              fpl_pkg::fpl_main0_hi);
   assign in_main1 = in_range(cpu_req.addr, fpl_pkg::fpl_main1_lo,
                              fpl_pkg::fpl_main1_hi);
   assign in_data = in_range(cpu_req.addr, fpl_pkg::fpl_data_lo,
                             fpl_pkg::fpl_data_hi);

   always_comb
   begin
      if (in_main0)
         sect_en = s_q.prog_low_wen[cpu_req.addr[16:13]];
      else if (in_main1)
         sect_en = s_q.prog_high_wen[cpu_req.addr[16:13]];
      else if (in_data)
         sect_en = s_q.data_wen[cpu_req.addr[12:9]];
      else
         sect_en = 1'b0;
   end

   always_comb
   begin
      cpu_allow = 1'b0;
      if (cpu_req.valid)
      begin
         if (!cpu_req.write)
            cpu_allow = in_main0 | in_main1 | in_data;
         else if (in_boot)
            cpu_allow = 1'b0;
         else
            cpu_allow = sect_en & ~write_lock;
      end
   end

   always_comb
   begin
      info_allow = 1'b0;
      if (info_req.valid)
      begin
         if (!info_req.write)
            info_allow = 1'b1;
         else if (info_req.prog_bank && (info_req.addr <= fpl_pkg::fpl_info0_hi))
            info_allow = 1'b0;
         else if (info_req.prog_bank)
            info_allow = ~write_lock & s_q.prog_high_wen[0];
         else
            info_allow = ~write_lock & ~info_req.addr[7];
      end
   end

   assign entry_ok = (internal_run_environment | external_run_environment) &
                     boot_defined & prot_word.loader_present_flag;

   // ==========================================================
   // APB and trigger
   logic wr_en;
   logic rd_en;
   logic [7:0] wbyte;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign wbyte = pwdata[7:0];

   always_comb
   begin
      s_d = s_q;
      if (rd_en)
      begin
         case (paddr)
            fpl_pkg::fpl_off_prog_low_wen: s_d.rdata = {16'h0000, s_q.prog_low_wen};
            fpl_pkg::fpl_off_prog_high_wen: s_d.rdata = {16'h0000, s_q.prog_high_wen};
            fpl_pkg::fpl_off_data_wen: s_d.rdata = {16'h0000, s_q.data_wen};
            fpl_pkg::fpl_off_status:
            begin
               s_d.rdata = 32'h0;
               s_d.rdata[fpl_pkg::fpl_status_loader_flag_bit] = s_q.loader_flag;
               s_d.rdata[fpl_pkg::fpl_status_isp_bit] = s_q.sticky_entry;
               s_d.rdata[fpl_pkg::fpl_status_busy_bit] = flash_busy;
            end
            default: s_d.rdata = 32'h0;
         endcase
      end
      if (s_q.trig == st_armed)
      begin
         if (s_q.cnt == fpl_pkg::fpl_window_cycles)
            s_d.trig = st_idle;
         else
            s_d.cnt = s_q.cnt + 7'h01;
      end
      if (wr_en)
      begin
         case (paddr)
            fpl_pkg::fpl_off_prog_low_wen: s_d.prog_low_wen = pwdata[15:0];
            fpl_pkg::fpl_off_prog_high_wen: s_d.prog_high_wen = pwdata[15:0];
            fpl_pkg::fpl_off_data_wen: s_d.data_wen = pwdata[15:0];
            fpl_pkg::fpl_off_soft_reset_trigger:
            begin
               if (s_q.trig == st_armed && wbyte == fpl_pkg::fpl_code_enter)
               begin
                  s_d.trig = entry_ok ? st_wait : st_idle;
                  s_d.entry_pending = entry_ok;
               end
               else if (s_q.trig == st_armed && wbyte == fpl_pkg::fpl_code_exit)
               begin
                  s_d.trig = st_wait;
                  s_d.entry_pending = 1'b0;
               end
               else if (s_q.trig != st_wait && wbyte == fpl_pkg::fpl_code_arm)
               begin
                  s_d.trig = st_armed;
                  s_d.cnt = 7'h00;
               end
               else if (s_q.trig != st_wait)
                  s_d.trig = st_idle;
            end
            default: ;
         endcase
      end
      if (s_q.trig == st_wait && !flash_busy)
      begin
         s_d.reset_req = 1'b1;
         s_d.trig = st_idle;
         s_d.sticky_entry = s_q.entry_pending;
         s_d.loader_flag = s_q.entry_pending;
      end
   end

   // reset clears enables
   // Loader state survives warm resets; a cold reset or a loader exit clears it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q.trig <= st_idle;
         s_q.cnt <= 7'h00;
         s_q.entry_pending <= 1'b0;
         s_q.prog_low_wen <= fpl_pkg::fpl_wen_reset;
         s_q.prog_high_wen <= fpl_pkg::fpl_wen_reset;
         s_q.data_wen <= fpl_pkg::fpl_wen_reset;
         s_q.rdata <= 32'h0;
         s_q.reset_req <= 1'b0;
      end
      else
      begin
         s_q.trig <= s_d.trig;
         s_q.cnt <= s_d.cnt;
         s_q.entry_pending <= s_d.entry_pending;
         s_q.prog_low_wen <= s_d.prog_low_wen;
         s_q.prog_high_wen <= s_d.prog_high_wen;
         s_q.data_wen <= s_d.data_wen;
         s_q.rdata <= s_d.rdata;
         s_q.reset_req <= s_d.reset_req;
         if (cold_reset)
         begin
            s_q.sticky_entry <= 1'b0;
            s_q.loader_flag <= 1'b0;
         end
         else
         begin
            s_q.sticky_entry <= s_d.sticky_entry;
            s_q.loader_flag <= s_d.loader_flag;
         end
      end
   end

   assign prdata = s_q.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign loader_reset_req = s_q.reset_req;
   assign in_system_programming_mode = s_q.sticky_entry | prot_word.blank;

endmodule : fpl_core
`default_nettype wire

// *** core/fpl_pkg.sv ***
// Package for the flash protection and loader reset block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package fpl_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [11:0] fpl_off_soft_reset_trigger = 12'h000;
   localparam logic [11:0] fpl_off_prog_low_wen = 12'h004;
   localparam logic [11:0] fpl_off_prog_high_wen = 12'h008;
   localparam logic [11:0] fpl_off_data_wen = 12'h00c;
   localparam logic [11:0] fpl_off_status = 12'h010;

   // ==========================================================
   // Reset values and field positions
   localparam logic [15:0] fpl_wen_reset = 16'h0000;
   localparam int fpl_status_loader_flag_bit = 7;
   localparam int fpl_status_busy_bit = 3;
   localparam int fpl_status_isp_bit = 4;

   // ==========================================================
   // Trigger codes and timing
   localparam logic [7:0] fpl_code_arm = 8'he1;
   localparam logic [7:0] fpl_code_enter = 8'h3e;
   localparam logic [7:0] fpl_code_exit = 8'h0e;
   localparam logic [6:0] fpl_window_cycles = 7'h7f;

   // ==========================================================
   // Memory map
   localparam logic [23:0] fpl_boot_max = 24'h0077ff;
   localparam logic [23:0] fpl_main0_lo = 24'h000000;
   localparam logic [23:0] fpl_main0_hi = 24'h01ffff;
   localparam logic [23:0] fpl_main1_lo = 24'h020000;
   localparam logic [23:0] fpl_main1_hi = 24'h03ffff;
   localparam logic [23:0] fpl_data_lo = 24'h0d0000;
   localparam logic [23:0] fpl_data_hi = 24'h0d1fff;
   localparam logic [3:0] fpl_boot_undefined = 4'hf;
   localparam logic [7:0] fpl_info0_hi = 8'h7f;
   localparam logic [7:0] fpl_func_word = 8'h7e;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic [2:0] global_write_lock;
      logic [2:0] global_read_lock;
      logic [3:0] boot_region_end;
      logic loader_present_flag;
      logic blank;
   } fpl_prot_word_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [23:0] addr;
   } fpl_cpu_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic prog_bank;
      logic [7:0] addr;
   } fpl_info_req_s;

endpackage : fpl_pkg

// *** dv/fpl_core_properties.sv ***
// Checker for the flash protection and loader reset block.
// Assumes it is bound to fpl_core and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module fpl_props
(
   // APB slave side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Device environment and access checks
   input wire logic internal_run_environment,
   input wire logic external_run_environment,
   input wire fpl_pkg::fpl_prot_word_s prot_word,
   input wire logic flash_busy,
   input wire fpl_pkg::fpl_cpu_req_s cpu_req,
   input wire logic cpu_allow,
   input wire fpl_pkg::fpl_info_req_s info_req,
   input wire logic info_allow,
   input wire logic debug_read_allow,
   input wire logic loader_reset_req
);
   // ==========================================================
   // Helpers
   logic wr_trig, env_ok;
   function automatic logic zero_maj(input logic [2:0] v);
      return !((v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]));
   endfunction : zero_maj
   assign wr_trig = psel && penable && pwrite
      && paddr == fpl_pkg::fpl_off_soft_reset_trigger;
   assign env_ok = (internal_run_environment || external_run_environment)
      && prot_word.boot_region_end != fpl_pkg::fpl_boot_undefined
      && prot_word.loader_present_flag;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // Trigger sequences
   sequence s_arm;
      wr_trig && pwdata[7:0] == fpl_pkg::fpl_code_arm;
   endsequence
   sequence s_enter;
      wr_trig && pwdata[7:0] == fpl_pkg::fpl_code_enter && !flash_busy;
   endsequence
   sequence s_exit;
      wr_trig && pwdata[7:0] == fpl_pkg::fpl_code_exit && !flash_busy;
   endsequence

   // ==========================================================
   // Properties
   property p_apb; pready && !pslverr; endproperty
   property p_enter; s_arm ##2 (s_enter ##0 env_ok) |-> ##[1:3] loader_reset_req;
   endproperty
   property p_exit; s_arm ##2 s_exit |-> ##[1:3] loader_reset_req; endproperty
   property p_refuse;
      s_arm ##2 (s_enter ##0 (!env_ok && !loader_reset_req))
         |-> (!loader_reset_req)[*4];
   endproperty
   property p_sticky; loader_reset_req |=> loader_reset_req; endproperty
   property p_busy; flash_busy && !loader_reset_req |=> !loader_reset_req;
   endproperty
   property p_wlock; cpu_req.valid && cpu_req.write
      && zero_maj(prot_word.global_write_lock) |-> !cpu_allow; endproperty
   property p_boot; cpu_req.valid && cpu_req.write && cpu_req.addr == 24'h000000
      && prot_word.boot_region_end != 4'hf |-> !cpu_allow; endproperty
   property p_rlock; zero_maj(prot_word.global_read_lock) |-> !debug_read_allow;
   endproperty
   property p_info0; info_req.valid && info_req.write && info_req.prog_bank
      && info_req.addr <= fpl_pkg::fpl_info0_hi |-> !info_allow; endproperty

   a_apb: assert property (p_apb)
      else $error("bus answer not zero wait");
   a_enter: assert property (p_enter)
      else $error("entry sequence gave no reset request");
   a_exit: assert property (p_exit)
      else $error("exit sequence gave no reset request");
   a_refuse: assert property (p_refuse)
      else $error("entry accepted without its conditions");
   a_sticky: assert property (p_sticky)
      else $error("reset request dropped");
   a_busy: assert property (p_busy)
      else $error("reset request while flash busy");
   a_wlock: assert property (p_wlock)
      else $error("write allowed under global lock");
   a_boot: assert property (p_boot)
      else $error("write allowed into boot region");
   a_rlock: assert property (p_rlock)
      else $error("debug read allowed under read lock");
   a_info0: assert property (p_info0)
      else $error("write allowed into first info block");
endmodule : fpl_props
bind fpl_core fpl_props fpl_props_inst (.*);
`default_nettype wire

// *** dv/fpl_core_tb.sv ***
// Self-checking testbench for the flash protection and loader reset block.
// Assumes fpl_core answers APB with zero wait and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module fpl_core_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cold_reset;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic internal_run_environment, external_run_environment, flash_busy;
   logic cpu_allow, info_allow, debug_read, debug_read_allow;
   logic loader_reset_req, in_system_programming_mode;
   fpl_pkg::fpl_prot_word_s prot_word;
   fpl_pkg::fpl_cpu_req_s cpu_req;
   fpl_pkg::fpl_info_req_s info_req;
   int n_fail, compares, cyc;
   typedef struct packed {
      logic [2:0] wl;
      logic [2:0] rl;
      logic w;
      logic [23:0] a;
      logic ec;
      logic ed;
   } fpl_row_s;
   fpl_row_s rows [11] = '{
      '{3'h7, 3'h7, 1'h1, 24'h002000, 1'h1, 1'h1},
      '{3'h7, 3'h7, 1'h1, 24'h004000, 1'h0, 1'h1},
      '{3'h7, 3'h6, 1'h1, 24'h020000, 1'h1, 1'h1},
      '{3'h7, 3'h4, 1'h1, 24'h03e000, 1'h1, 1'h0},
      '{3'h3, 3'h0, 1'h1, 24'h0d0000, 1'h1, 1'h0},
      '{3'h7, 3'h7, 1'h1, 24'h0d0200, 1'h0, 1'h1},
      '{3'h1, 3'h7, 1'h1, 24'h020000, 1'h0, 1'h1},
      '{3'h4, 3'h7, 1'h1, 24'h002000, 1'h0, 1'h1},
      '{3'h7, 3'h7, 1'h1, 24'h000000, 1'h0, 1'h1},
      '{3'h0, 3'h7, 1'h0, 24'h000000, 1'h1, 1'h1},
      '{3'h7, 3'h7, 1'h0, 24'h0d1ffe, 1'h1, 1'h1}};

   fpl_core fpl_core_inst (.*);

   initial
   begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         results();
      end
   end

   // ==========================================================
   // Tasks
   task chkb(input string n, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask : chkb
   task chkw(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chkw
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
   endtask : apb
   task idle;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : idle
   task rst;
      presetn <= 1'h0;
      psel <= 1'h0;
      penable <= 1'h0;
      tick(10);
      presetn <= 1'h1;
      tick(1);
   endtask : rst
   task trig(input logic [7:0] c, input int gap);
      apb(1'h1, 12'h000, 32'h000000e1);
      if (gap > 0)
      begin
         idle();
         tick(gap);
      end
      apb(1'h1, 12'h000, {24'h000000, c});
      idle();
   endtask : trig
   task status(input logic [31:0] e);
      apb(1'h0, 12'h010, 32'h00000000);
      idle();
      chkw("status", e, rd & 32'h00000098);
   endtask : status
   task results;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // ==========================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, cold_reset, flash_busy} = 6'h02;
      {paddr, pwdata, cpu_req, info_req} = '0;
      internal_run_environment = 1'h1;
      external_run_environment = 1'h0;
      debug_read = 1'h1;
      prot_word = '{3'h7, 3'h7, 4'h0, 1'h1, 1'h0};
      {n_fail, compares, cyc} = '0;
      tick(10);
      presetn <= 1'h1;
      tick(1);
      cold_reset <= 1'h0;
      for (int i = 1; i < 4; i++)
      begin
         apb(1'h0, 12'(4 * i), 32'h00000000);
         chkw("wen_reset", 32'h00000000, rd);
      end
      apb(1'h1, 12'h004, 32'h00000003);
      apb(1'h1, 12'h008, 32'h00008001);
      apb(1'h1, 12'h00c, 32'h00000001);
      apb(1'h1, 12'h020, 32'h0000ffff);
      apb(1'h0, 12'h020, 32'h00000000);
      chkw("unmapped", 32'h00000000, rd);
      apb(1'h0, 12'h008, 32'h00000000);
      chkw("wen_rw", 32'h00008001, rd);
      idle();
      $display("test registers done");
      foreach (rows[i])
      begin
         prot_word.global_write_lock <= rows[i].wl;
         prot_word.global_read_lock <= rows[i].rl;
         cpu_req <= '{1'h1, rows[i].w, rows[i].a};
         @(posedge pclk);
         chkb("cpu_allow", rows[i].ec, cpu_allow);
         chkb("debug_allow", rows[i].ed, debug_read_allow);
      end
      for (int i = 1; i < 4; i++)
         apb(1'h1, 12'(4 * i), 32'h00000000);
      apb(1'h0, 12'h008, 32'h00000000);
      chkw("wen_clear", 32'h00000000, rd);
      idle();
      $display("test access table done");
      info_req <= '{1'h1, 1'h1, 1'h1, 8'h7e};
      tick(1);
      chkb("info0_write", 1'h0, info_allow);
      info_req <= '{1'h1, 1'h0, 1'h1, 8'h7e};
      tick(1);
      chkb("info0_read", 1'h1, info_allow);
      $display("test info done");
      for (int j = 0; j < 3; j++)
      begin
         internal_run_environment <= (j != 0);
         prot_word.boot_region_end <= (j == 1) ? 4'hf : 4'h0;
         prot_word.loader_present_flag <= (j != 2);
         trig(8'h3e, 0);
         tick(4);
         chkb("entry_refused", 1'h0, loader_reset_req);
      end
      internal_run_environment <= 1'h1;
      prot_word.boot_region_end <= 4'h0;
      prot_word.loader_present_flag <= 1'h1;
      trig(8'h3e, 130);
      tick(4);
      chkb("window_expired", 1'h0, loader_reset_req);
      apb(1'h1, 12'h000, 32'h000000e1);
      trig(8'h55, 0);
      apb(1'h1, 12'h000, 32'h0000003e);
      idle();
      tick(4);
      chkb("disarmed", 1'h0, loader_reset_req);
      flash_busy <= 1'h1;
      trig(8'h3e, 0);
      tick(8);
      chkb("busy_hold", 1'h0, loader_reset_req);
      flash_busy <= 1'h0;
      tick(4);
      chkb("entry_req", 1'h1, loader_reset_req);
      rst();
      status(32'h00000090);
      chkb("isp_sticky", 1'h1, in_system_programming_mode);
      apb(1'h0, 12'h004, 32'h00000000);
      chkw("wen_warm", 32'h00000000, rd);
      idle();
      $display("test entry done");
      internal_run_environment <= 1'h0;
      trig(8'h0e, 0);
      tick(4);
      chkb("exit_req", 1'h1, loader_reset_req);
      rst();
      status(32'h00000000);
      chkb("isp_cleared", 1'h0, in_system_programming_mode);
      prot_word.blank <= 1'h1;
      tick(1);
      chkb("isp_blank", 1'h1, in_system_programming_mode);
      prot_word.blank <= 1'h0;
      internal_run_environment <= 1'h1;
      trig(8'h3e, 0);
      tick(4);
      rst();
      cold_reset <= 1'h1;
      tick(1);
      cold_reset <= 1'h0;
      tick(1);
      status(32'h00000000);
      chkb("isp_cold", 1'h0, in_system_programming_mode);
      $display("test exit and cold reset done");
      results();
   end
endmodule : fpl_core_tb
`default_nettype wire
